//--- rtl/spi_port_pkg.sv
`default_nettype none

package spi_port_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] DATA_OFFSET = 8'hf7;   // Serial data register
   localparam logic [7:0] CTRL_OFFSET = 8'hf8;   // Serial control register
   localparam logic [7:0] DATA_RESET  = 8'h00;   // Data register after reset
   localparam logic [7:0] CTRL_RESET  = 8'h04;   // Control register after reset

   // ****************************************
   // Control field positions
   // ****************************************
   localparam int DONE_BIT    = 7;   // Transfer done flag
   localparam int WRITE_COLLISION_FLAG_BIT    = 6;   // Write collision flag
   localparam int IFACE_BIT   = 5;   // Interface select
   localparam int MASTER_BIT  = 4;   // Master select
   localparam int CLOCK_IDLE_LEVEL_BIT    = 3;   // Clock idle level
   localparam int CLOCK_PHASE_SELECT_BIT    = 2;   // Clock phase select
   localparam int RATE_HI_BIT = 1;   // Rate select high
   localparam int RATE_LO_BIT = 0;   // Rate select low, slave-select readback

   // ****************************************
   // Byte framing counts
   // ****************************************
   localparam logic [3:0] BYTE_BITS = 4'h8;   // Bits per byte
   localparam logic [3:0] LAST_EDGE = 4'hf;   // Sixteenth clock edge of a master byte

   // ****************************************
   // Synchroniser lane positions
   // ****************************************
   localparam int PIN_SCLK = 0;   // Serial clock line in
   localparam int PIN_MOSI = 1;   // Master-out line in
   localparam int PIN_MISO = 2;   // Master-in line in
   localparam int PIN_SS   = 3;   // Slave select in, active low

   // Master sequencer states, Gray along idle to run
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01
   } xfer_state_t;

endpackage : spi_port_pkg

`default_nettype wire

//--- rtl/rate_if.sv
`default_nettype none

// Bundle between the port and its bit-rate divider
interface rate_if;
   logic       run;    // Divider counts while high
   logic [1:0] rate;   // Rate select code
   logic       tick;   // One-cycle pulse at each half period
   modport gen (input run, input rate, output tick);
   modport ctl (output run, output rate, input tick);
endinterface : rate_if

`default_nettype wire

//--- rtl/rate_divider.sv
`default_nettype none

module rate_divider #(
   parameter int CNT_W = 4                    // Wide enough for the slowest half period
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   rate_if.gen       rif
);

   // ****************************************
   // Half-period divider
   // ****************************************
   logic [CNT_W-1:0] cnt_ff;      // Cycles into the current half period
   logic [CNT_W-1:0] nxt_cnt;     // Next count
   logic [CNT_W-1:0] limit;       // Last count of a half period

   // Half period is 2^code core cycles, so a full period divides by 2, 4, 8 or 16
   function automatic logic [CNT_W-1:0] half_limit(input logic [1:0] code);
      return CNT_W'((1 << code) - 1);
   endfunction : half_limit

   // Next count and the tick
   always_comb begin
      limit    = half_limit(rif.rate);
      rif.tick = rif.run && (cnt_ff == limit);
      if (!rif.run || rif.tick) begin
         nxt_cnt = '0;   // Restart so every burst begins with a full half period
      end else begin
         nxt_cnt = cnt_ff + 1'b1;
      end
   end

   // Count register
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule : rate_divider

`default_nettype wire

//--- rtl/spi_master_slave_port.sv
// Decided for this implementation: the plain strobed port.
`default_nettype none

module spi_master_slave_port (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic       i_sclk,
   output logic            o_sclk,
   output logic            o_sclk_oe,
   input  wire logic       i_mosi,
   output logic            o_mosi,
   output logic            o_mosi_oe,
   input  wire logic       i_miso,
   output logic            o_miso,
   output logic            o_miso_oe,
   input  wire logic       i_ss_n,
   output logic            o_transfer_done_flag
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0] meta_ff;    // First stage, read only by the second
   logic [3:0] sync_ff;    // Pin levels safe for logic
   logic [1:0] prev_ff;    // Delayed clock and select for edge finding

   // Two flops per pin, then one more for the edge detectors
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_ff <= 4'h8;
         sync_ff <= 4'h8;
         prev_ff <= 2'h2;
      end else begin
         meta_ff <= {i_ss_n, i_miso, i_mosi, i_sclk};
         sync_ff <= meta_ff;
         prev_ff <= {sync_ff[spi_port_pkg::PIN_SS], sync_ff[spi_port_pkg::PIN_SCLK]};
      end
   end

   // ****************************************
   // State registers
   // ****************************************
   logic [5:0]                ctl_ff;     // Software-owned control bits 5..0
   logic                      done_ff;    // Transfer done flag
   logic                      write_collision_flag_ff;    // Write collision flag
   logic [7:0]                data_ff;    // Last completed received byte
   logic [7:0]                sh_ff;      // Shared shift register
   logic                      out_ff;     // Bit presented on the data output
   spi_port_pkg::xfer_state_t state_ff;   // Master sequencer
   logic [3:0]                edge_ff;    // Master clock edges done
   logic                      sclk_ff;    // Master clock level
   logic [3:0]                scnt_ff;    // Slave bits sampled
   logic [7:0]                rdata_ff;   // Read data, valid the cycle after a read

   logic [5:0]                nxt_ctl;
   logic                      nxt_done;
   logic                      nxt_write_collision_flag;
   logic [7:0]                nxt_data;
   logic [7:0]                nxt_sh;
   logic                      nxt_out;
   spi_port_pkg::xfer_state_t nxt_state;
   logic [3:0]                nxt_edge;
   logic                      nxt_sclk;
   logic [3:0]                nxt_scnt;
   logic [7:0]                nxt_rdata;

   // ****************************************
   // Decoded controls and events
   // ****************************************
   logic       iface_on;    // Serial port owns the pins
   logic       master_on;   // Active as master
   logic       slave_on;    // Active as slave
   logic       clock_idle_level;        // Clock idle level
   logic       clock_phase_select;        // Clock phase
   logic       ss_hi;       // Synchronised select, high means deselected
   logic       ss_rise;     // Select just returned high
   logic       m_ev;        // Master clock edge this cycle
   logic       s_ev;        // Slave clock edge this cycle
   logic       lead;        // The edge is a leading one
   logic       shift_ev;    // Sample edge
   logic       drive_ev;    // Drive edge
   logic       in_bit;      // Serial input for the active role
   logic [7:0] shifted;     // Shift register after this cycle's sample
   logic       busy;        // A byte is under way
   logic       data_wr;     // Software writes the data register
   logic       data_rd;     // Software reads the data register
   logic       ctl_wr;      // Software writes the control register
   logic       done_evt;    // A byte has just completed
   logic [7:0] ctl_view;    // Control register as software reads it

   rate_if rif ();

   // Decodes and edge classification
   always_comb begin
      iface_on  = ctl_ff[spi_port_pkg::IFACE_BIT];
      master_on = iface_on && ctl_ff[spi_port_pkg::MASTER_BIT];
      slave_on  = iface_on && !ctl_ff[spi_port_pkg::MASTER_BIT];
      clock_idle_level      = ctl_ff[spi_port_pkg::CLOCK_IDLE_LEVEL_BIT];
      clock_phase_select      = ctl_ff[spi_port_pkg::CLOCK_PHASE_SELECT_BIT];
      ss_hi     = sync_ff[spi_port_pkg::PIN_SS];
      ss_rise   = ss_hi && !prev_ff[1];
      // Master never looks at the select pin
      m_ev      = (state_ff == spi_port_pkg::ST_RUN) && rif.tick;
      s_ev      = slave_on && !ss_hi
                  && (sync_ff[spi_port_pkg::PIN_SCLK] != prev_ff[0]);
      // Master edges alternate from leading; a slave edge leads when it leaves idle
      lead      = master_on ? !edge_ff[0] : (sync_ff[spi_port_pkg::PIN_SCLK] != clock_idle_level);
      // Phase zero samples on leading, phase one on trailing
      shift_ev  = (m_ev || s_ev) && (lead != clock_phase_select);
      drive_ev  = (m_ev || s_ev) && (lead == clock_phase_select);
      in_bit    = master_on ? sync_ff[spi_port_pkg::PIN_MISO]
                            : sync_ff[spi_port_pkg::PIN_MOSI];
      // Receive enters at the bottom, transmit leaves the top: MSB first
      shifted   = shift_ev ? {sh_ff[6:0], in_bit} : sh_ff;
      busy      = (state_ff == spi_port_pkg::ST_RUN)
                  || (slave_on && !ss_hi && (scnt_ff != 4'h0));
      data_wr   = i_wr && (i_addr == spi_port_pkg::DATA_OFFSET);
      data_rd   = i_rd && (i_addr == spi_port_pkg::DATA_OFFSET);
      ctl_wr    = i_wr && (i_addr == spi_port_pkg::CTRL_OFFSET);
      // In slave mode bit 0 shows the live select level
      ctl_view  = {done_ff, write_collision_flag_ff, ctl_ff[5:1],
                   master_on ? ctl_ff[spi_port_pkg::RATE_LO_BIT] : ss_hi};
      rif.run   = (state_ff == spi_port_pkg::ST_RUN);
      rif.rate  = ctl_ff[spi_port_pkg::RATE_HI_BIT:spi_port_pkg::RATE_LO_BIT];
   end

   // Rate divider for the master clock
   rate_divider #(
      .CNT_W (4)
   ) u_div (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .rif   (rif.gen)
   );

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      nxt_ctl   = ctl_ff;
      nxt_done  = done_ff;
      nxt_write_collision_flag  = write_collision_flag_ff;
      nxt_data  = data_ff;
      nxt_sh    = shifted;
      nxt_out   = drive_ev ? sh_ff[7] : out_ff;
      nxt_state = state_ff;
      nxt_edge  = edge_ff;
      nxt_sclk  = sclk_ff;
      nxt_scnt  = scnt_ff;
      nxt_rdata = 8'h00;
      done_evt  = 1'b0;

      // Master sequencer
      case (state_ff)
         spi_port_pkg::ST_IDLE: begin
            nxt_sclk = clock_idle_level;
            nxt_edge = 4'h0;
            // Write starts a burst and presents the MSB ahead of the first edge
            if (data_wr && master_on) begin
               nxt_state = spi_port_pkg::ST_RUN;
               nxt_sh    = i_wdata;
               nxt_out   = i_wdata[7];
            end
         end
         spi_port_pkg::ST_RUN: begin
            if (rif.tick) begin
               nxt_sclk = ~sclk_ff;
               nxt_edge = edge_ff + 4'h1;
               // Sixteen edges make eight full clock periods
               if (edge_ff == spi_port_pkg::LAST_EDGE) begin
                  nxt_state = spi_port_pkg::ST_IDLE;
                  done_evt  = 1'b1;
               end
            end
         end
         default: begin
            nxt_state = spi_port_pkg::ST_IDLE;
         end
      endcase

      // Slave byte tracking
      if (slave_on) begin
         // Phase zero: the byte ends only when select is released
         if (ss_rise && !clock_phase_select && (scnt_ff == spi_port_pkg::BYTE_BITS)) begin
            done_evt = 1'b1;
         end
         if (ss_hi) begin
            nxt_scnt = 4'h0;
         end else if (shift_ev && (scnt_ff != spi_port_pkg::BYTE_BITS)) begin
            // Phase one: the eighth sample ends the byte, select may stay low
            if (clock_phase_select && (scnt_ff == spi_port_pkg::BYTE_BITS - 4'h1)) begin
               done_evt = 1'b1;
               nxt_scnt = 4'h0;
            end else begin
               nxt_scnt = scnt_ff + 4'h1;
            end
         end
         // A write between bytes loads the outgoing byte
         if (data_wr && !busy) begin
            nxt_sh  = i_wdata;
            nxt_out = i_wdata[7];
         end
      end else begin
         nxt_scnt = 4'h0;
      end

      // Control write; flag bits clear when written with zero; a data read also clears done
      if (ctl_wr) begin
         nxt_ctl = i_wdata[5:0];
         if (!i_wdata[spi_port_pkg::DONE_BIT]) begin
            nxt_done = 1'b0;
         end
         if (!i_wdata[spi_port_pkg::WRITE_COLLISION_FLAG_BIT]) begin
            nxt_write_collision_flag = 1'b0;
         end
      end
      if (data_rd) begin
         nxt_done = 1'b0;
      end

      // Completion latches the received byte; a set beats a clear
      if (done_evt) begin
         nxt_done = 1'b1;
         nxt_data = shifted;
      end

      // A write while busy is refused and only flagged
      if (data_wr && busy) begin
         nxt_write_collision_flag = 1'b1;
      end

      // Register read mux, unmapped reads return zero
      if (i_rd) begin
         if (i_addr == spi_port_pkg::DATA_OFFSET) begin
            nxt_rdata = data_ff;
         end else if (i_addr == spi_port_pkg::CTRL_OFFSET) begin
            nxt_rdata = ctl_view;
         end else begin
            nxt_rdata = 8'h00;
         end
      end
   end

   // Register everything
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctl_ff   <= spi_port_pkg::CTRL_RESET[5:0];
         done_ff  <= spi_port_pkg::CTRL_RESET[spi_port_pkg::DONE_BIT];
         write_collision_flag_ff  <= spi_port_pkg::CTRL_RESET[spi_port_pkg::WRITE_COLLISION_FLAG_BIT];
         data_ff  <= spi_port_pkg::DATA_RESET;
         sh_ff    <= spi_port_pkg::DATA_RESET;
         out_ff   <= 1'b0;
         state_ff <= spi_port_pkg::ST_IDLE;
         edge_ff  <= 4'h0;
         sclk_ff  <= spi_port_pkg::CTRL_RESET[spi_port_pkg::CLOCK_IDLE_LEVEL_BIT];
         scnt_ff  <= 4'h0;
         rdata_ff <= 8'h00;
      end else begin
         ctl_ff   <= nxt_ctl;
         done_ff  <= nxt_done;
         write_collision_flag_ff  <= nxt_write_collision_flag;
         data_ff  <= nxt_data;
         sh_ff    <= nxt_sh;
         out_ff   <= nxt_out;
         state_ff <= nxt_state;
         edge_ff  <= nxt_edge;
         sclk_ff  <= nxt_sclk;
         scnt_ff  <= nxt_scnt;
         rdata_ff <= nxt_rdata;
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   // With the interface deselected the pins belong to the two-wire block
   always_comb begin
      o_sclk               = sclk_ff;
      o_sclk_oe            = master_on;
      o_mosi               = out_ff;
      o_mosi_oe            = master_on;
      o_miso               = out_ff;
      o_miso_oe            = slave_on && !ss_hi;
      o_rdata              = rdata_ff;
      o_transfer_done_flag = done_ff;
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   logic [4:0] gap_ff;       // Cycles since the previous divider tick
   logic [7:0] run_len_ff;   // Cycles into the current burst, zero while idle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         gap_ff     <= 5'h00;
         run_len_ff <= 8'h00;
      end else begin
         gap_ff     <= (rif.tick || !rif.run) ? 5'h00 : gap_ff + 5'h01;
         run_len_ff <= (state_ff == spi_port_pkg::ST_RUN) ? run_len_ff + 8'h01 : 8'h00;
      end
   end

   a_done_sets: assert property (done_evt |=> done_ff)
      else $error("done flag not set after byte end");
   a_read_clears: assert property (data_rd && !done_evt |=> !done_ff)
      else $error("data read did not clear done flag");
   a_write_collision_flag_sets: assert property (data_wr && busy && !done_evt
                                 |=> write_collision_flag_ff && $stable(state_ff))
      else $error("collision not flagged");
   a_iface_gates: assert property (!iface_on |-> !(o_sclk_oe || o_mosi_oe || o_miso_oe))
      else $error("pins driven while interface deselected");
   a_idle_level: assert property ((state_ff == spi_port_pkg::ST_IDLE) ##1 $stable(clock_idle_level)
                                  && (state_ff == spi_port_pkg::ST_IDLE) |-> o_sclk == clock_idle_level)
      else $error("idle clock level wrong");
   a_rate_divide: assert property (rif.tick && (edge_ff != 4'h0)
                                   |-> gap_ff == 5'((1 << rif.rate) - 1))
      else $error("half period length wrong");
   // Burst length is counted, not repeated, so long rates stay cheap for the tools
   a_burst_len: assert property ((state_ff == spi_port_pkg::ST_RUN)
                                 && (nxt_state == spi_port_pkg::ST_IDLE)
                                 |-> run_len_ff == 8'((16 << rif.rate) - 1))
      else $error("burst length wrong");
   a_ss_readback: assert property (i_rd && (i_addr == spi_port_pkg::CTRL_OFFSET)
                                   && slave_on |=> o_rdata[0] == $past(ss_hi))
      else $error("select level not readable");
   a_byte_latch: assert property (done_evt |=> data_ff == $past(shifted))
      else $error("received byte not latched");
   a_no_disturb: assert property (data_wr && (state_ff == spi_port_pkg::ST_RUN)
                                  && !rif.tick |=> {sh_ff, out_ff} == $past({sh_ff, out_ff}))
      else $error("collision write disturbed shift");

   c_master_byte: cover property (m_ev && (edge_ff == spi_port_pkg::LAST_EDGE));
   c_slave_byte: cover property (slave_on && done_evt);
   c_collision: cover property (data_wr && busy);

endmodule : spi_master_slave_port

`default_nettype wire

//--- verification/spi_slave_model.sv
`default_nettype none

// Serial peripheral that answers the port while it is master
module spi_slave_model (
   input  wire logic       i_sclk,
   input  wire logic       i_mosi,
   input  wire logic       i_clock_idle_level,
   input  wire logic       i_clock_phase_select,
   input  wire logic       i_load,
   input  wire logic [7:0] i_tx,
   output logic            o_miso,
   output logic      [7:0] o_rx
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] tx;   // Bits still to send

   // ****************************************
   // Shift logic
   // ****************************************
   initial begin
      o_miso = 1'b0;
      o_rx   = 8'h00;
   end

   // Select is not wired: the master never drives one
   always @(posedge i_load or i_sclk) begin
      if (i_load) begin
         tx     <= i_clock_phase_select ? i_tx : {i_tx[6:0], ~i_tx[0]};
         o_miso <= i_clock_phase_select ? ~i_tx[7] : i_tx[7];   // Phase 0 shows the first bit early
         o_rx   <= 8'h00;
      end else if (i_sclk == (i_clock_idle_level ~^ i_clock_phase_select)) begin
         o_rx <= {o_rx[6:0], i_mosi};   // Sample edge, MSB first
      end else begin
         o_miso <= tx[7];   // Drive edge
         tx     <= {tx[6:0], ~tx[7]};   // Junk that toggles once the byte is out
      end
   end
endmodule : spi_slave_model

`default_nettype wire

//--- verification/spi_master_slave_port_tb.sv
`default_nettype none

module spi_master_slave_port_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Bench signals
   // ****************************************
   localparam int HP = 8;   // Far master half period, slow for the pin synchroniser
   logic       clk, rst, wr, rd, sclk, mosi, ss_n, load, prev;
   logic [7:0] addr, wdata, rdata, mtx, mrx, got, cfg, tx, exp;
   logic [1:0] rate;
   logic       o_sclk, sclk_oe, o_mosi, mosi_oe, miso, o_miso, miso_oe, done;
   int         err_total, cmp_count, tcnt, edges, first_c, last_c, cyc;

   spi_master_slave_port spi_master_slave_port_inst (
      .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_sclk(sclk), .o_sclk(o_sclk), .o_sclk_oe(sclk_oe), .i_mosi(mosi),
      .o_mosi(o_mosi), .o_mosi_oe(mosi_oe), .i_miso(miso), .o_miso(o_miso),
      .o_miso_oe(miso_oe), .i_ss_n(ss_n), .o_transfer_done_flag(done));

   spi_slave_model spi_slave_model_inst (
      .i_sclk(o_sclk), .i_mosi(o_mosi), .i_clock_idle_level(cfg[3]), .i_clock_phase_select(cfg[2]), .i_load(load),
      .i_tx(mtx), .o_miso(miso), .o_rx(mrx));

   // ****************************************
   // Clock, edge monitor, hang guard
   // ****************************************
   always #2.5 clk = ~clk;

   // Counts master clock toggles mid-cycle, where the pin has settled
   always @(negedge clk) begin
      cyc = cyc + 1;
      if (o_sclk !== prev) begin
         if (edges == 0) first_c = cyc;
         last_c = cyc;
         edges  = edges + 1;
      end
      prev = o_sclk;
   end

   always @(posedge clk) begin
      tcnt = tcnt + 1;
      if (tcnt == 5000) begin
         err_total = err_total + 1;
         final_report();
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd_reg

   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 600) begin
         @(posedge clk);
         n++;
      end
      #1 chk({7'h0, done}, 8'h01);
   endtask : wait_done

   // Bench acting as the far master while the port is slave
   task automatic ext_xfer(input logic [7:0] t, input logic clock_phase_select, output logic [7:0] r);
      ss_n <= 1'b0;   // Held low for the byte
      mosi <= t[7];
      repeat (HP) @(posedge clk);
      chk({7'h0, miso_oe}, 8'h01);
      for (int b = 7; b >= 0; b--) begin
         if (clock_phase_select) mosi <= t[b];
         else r[b] = o_miso;
         sclk <= ~sclk;
         repeat (HP) @(posedge clk);
         if (clock_phase_select) r[b] = o_miso;
         else if (b > 0) mosi <= t[b-1];
         sclk <= ~sclk;
         repeat (HP) @(posedge clk);
      end
      chk({7'h0, done}, {7'h0, clock_phase_select});
      ss_n <= 1'b1;
      mosi <= ~mosi;
      repeat (10) @(posedge clk);
      chk({7'h0, done}, 8'h01);
   endtask : ext_xfer

   task automatic final_report();
      $display("mismatches=%0d compares=%0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      clk = 0; rst = 1; wr = 0; rd = 0; addr = 0; wdata = 0; sclk = 0; mosi = 0;
      ss_n = 1; load = 0; cfg = 0; mtx = 0; prev = 0; err_total = 0; cmp_count = 0;
      tcnt = 0; edges = 0; cyc = 0; first_c = 0; last_c = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd_reg(spi_port_pkg::DATA_OFFSET, spi_port_pkg::DATA_RESET);
      rd_reg(spi_port_pkg::CTRL_OFFSET, spi_port_pkg::CTRL_RESET | 8'h01);
      rd_reg(8'h10, 8'h00);
      // Master: every clock mode, every rate code, a collision at i 5
      for (int i = 0; i < 8; i++) begin
         rate = (i < 4) ? 2'(i) : {1'b1, i[0]};
         cfg  = {4'h3, i[1], i[0], rate};
         ss_n <= ~i[1];   // Select pin toggled yet ignored
         wr_reg(spi_port_pkg::CTRL_OFFSET, cfg);
         #1 chk({6'h0, sclk_oe, mosi_oe}, 8'h03);
         // Clock pin takes the new idle level one cycle after the control write
         repeat (2) @(negedge clk);
         chk({7'h0, o_sclk}, {7'h0, cfg[3]});
         mtx  = 8'h5a + 8'(i * 23);
         load <= 1'b1;
         @(posedge clk);
         load <= 1'b0;
         edges = 0;
         tx = 8'hc3 ^ 8'(i * 17);
         wr_reg(spi_port_pkg::DATA_OFFSET, tx);
         if (i == 5) wr_reg(spi_port_pkg::DATA_OFFSET, ~tx);
         wait_done();
         chk(8'(edges), 8'd16);
         chk(8'(last_c - first_c), 8'd15 << rate);
         chk(mrx, tx);
         exp = {2'b10, cfg[5:0]} | ((i == 5) ? 8'h40 : 8'h00);
         rd_reg(spi_port_pkg::CTRL_OFFSET, exp);
         if (!rate[1] || i[0]) wr_reg(spi_port_pkg::CTRL_OFFSET, cfg);
         if (rate[1]) rd_reg(spi_port_pkg::DATA_OFFSET, mtx);
         rd_reg(spi_port_pkg::CTRL_OFFSET, cfg);
      end
      ss_n <= 1'b1;   // Deselected between slave bytes
      // Slave: every clock mode, far master clocked by the bench
      for (int i = 0; i < 4; i++) begin
         cfg  = {4'h2, i[1], i[0], 2'b00};
         sclk <= i[1];
         wr_reg(spi_port_pkg::CTRL_OFFSET, cfg);
         tx = 8'h81 + 8'(i * 45);
         wr_reg(spi_port_pkg::DATA_OFFSET, tx);
         rd_reg(spi_port_pkg::CTRL_OFFSET, cfg | 8'h01);
         mtx = 8'h3c ^ 8'(i * 9);
         ext_xfer(mtx, i[0], got);
         chk(got, tx);
         rd_reg(spi_port_pkg::DATA_OFFSET, mtx);
      end
      final_report();
   end
endmodule : spi_master_slave_port_tb

`default_nettype wire
